/* File: hdl/osd_decoder.sv */
// Operand specifier decoder: byte stream in, decoded operands out
// Operation
// RULE_01 - extension forms give sub-opcode digit 0-7
// RULE_02 - register forms: middle field selects word register
// RULE_03 - displacement follows specifier, before immediate data
// RULE_04 - signed displacement added to address offset
// RULE_05 - short branch: sign-extend, add to next offset
// RULE_06 - near branch: word added to next offset
// RULE_07 - far pointer: offset word, then selector word
// RULE_08 - opcode decides immediate byte signedness
// RULE_09 - multi-byte words arrive low byte first
// RULE_10 - register in opcode: opcode minus base
// RULE_11 - form 00: zero displacement, none fetched
// RULE_12 - form 01: one byte, sign-extended
// RULE_13 - form 10: two bytes, high above low
// RULE_14 - form 11: locator selects a register
// RULE_15 - locators 000-011: base plus index plus displacement
// RULE_16 - locators 100-111: one register plus displacement
// RULE_17 - form 00 locator 110: direct address
// RULE_18 - opcode alone sets immediate presence, size
// RULE_19 - report total length and next offset
`timescale 1ns/10ps
`default_nettype none
module osd_decoder (
    input wire logic clk, // Core clock
    input wire logic reset, // Synchronous reset
    input wire logic byte_valid, // Code byte offered
    input wire logic [7:0] byte_data, // Code byte
    output logic byte_ready, // Code byte accepted
    input wire logic [15:0] start_offset, // Offset of opcode byte
    input wire osd_pkg::osd_fmt_e desc_fmt, // Operand format of opcode
    input wire logic [1:0] desc_imm_size, // Immediate size of opcode
    input wire logic desc_imm_signed, // Immediate byte is signed
    input wire logic [7:0] desc_base_opcode, // Base for register in opcode
    input wire logic [15:0] base_word, // Base register value
    input wire logic [15:0] frame_base_word, // Frame base value
    input wire logic [15:0] src_index_word, // Source index value
    input wire logic [15:0] dest_index_word, // Destination index value
    output logic dec_done, // Decode result valid pulse
    output logic [2:0] reg_sel, // Register operand code
    output logic [2:0] ext_digit, // Sub-opcode digit
    output logic rm_is_reg, // Locator names a register
    output logic [2:0] rm_reg, // Register from locator
    output logic mem_op, // Memory operand present
    output logic [15:0] effective_address, // Memory operand offset
    output logic [15:0] imm_value, // Immediate operand
    output logic [15:0] target_ip, // New instruction pointer
    output logic [15:0] target_cs, // New code selector
    output logic [3:0] instr_len, // Total instruction bytes
    output logic [15:0] next_ip // Offset of next instruction
);
    import osd_pkg::*;

    typedef struct packed {
        osd_state_e state;
        osd_fmt_e fmt;
        logic [1:0] imm_size;
        logic imm_signed;
        logic [7:0] opcode;
        logic [7:0] base_op;
        logic [7:0] spec;
        logic [1:0] dneed;
        logic [1:0] dcnt;
        logic [2:0] need;
        logic [2:0] cnt;
        logic [15:0] disp;
        logic [31:0] data;
        logic [3:0] len;
        logic [15:0] start;
        logic ready;
        logic done;
        logic [2:0] reg_sel;
        logic [2:0] ext_digit;
        logic rm_is_reg;
        logic [2:0] rm_reg;
        logic mem_op;
        logic [15:0] ea;
        logic [15:0] imm;
        logic [15:0] target_ip;
        logic [15:0] target_cs;
        logic [3:0] instr_len;
        logic [15:0] next_ip;
    } osd_state_s;

    osd_state_s st;
    osd_state_s next_st;
    logic take;
    logic [1:0] mode;
    logic [2:0] loc;
    logic [15:0] nip;
    logic [7:0] rdiff;

    osd_ea_if eif ();

    // Sign extension of a byte, used for displacements and branches
    function automatic logic [15:0] sext8(input logic [7:0] b);
        sext8 = {{8{b[7]}}, b};
    endfunction

    // Displacement bytes implied by the specifier byte
    function automatic logic [1:0] disp_bytes(input logic [1:0] m, input logic [2:0] l);
        case (m)
            OSD_MODE_NODISP: disp_bytes = (l == OSD_LOC_DIRECT) ? 2'h2 : 2'h0; // [RULE_11]
            OSD_MODE_DISP8: disp_bytes = 2'h1; // [RULE_12]
            OSD_MODE_DISP16: disp_bytes = 2'h2; // [RULE_13]
            default: disp_bytes = 2'h0; // [RULE_14]
        endcase
    endfunction

    // Operand bytes after any displacement, known from the opcode alone
    function automatic logic [2:0] data_bytes(input osd_fmt_e f, input logic [1:0] isz);
        case (f)
            OSD_F_SHORT_REL: data_bytes = OSD_SHORT_BYTES;
            OSD_F_NEAR_REL: data_bytes = OSD_NEAR_BYTES;
            OSD_F_FAR_PTR: data_bytes = OSD_FAR_BYTES;
            default: data_bytes = {1'b0, isz}; // [RULE_18]
        endcase
    endfunction

    function automatic logic has_spec(input osd_fmt_e f);
        has_spec = (f == OSD_F_SPEC_REG) || (f == OSD_F_SPEC_EXT);
    endfunction

    // Handshake and decoded specifier fields
    assign take = byte_valid && st.ready;
    assign mode = st.spec[OSD_MODE_HI:OSD_MODE_LO];
    assign loc = st.spec[OSD_LOC_HI:OSD_LOC_LO];
    assign nip = st.start + {12'h0, st.len}; // [RULE_19]
    assign rdiff = st.opcode - st.base_op; // [RULE_10]

    // Address calculator sees registered fields and live register values
    assign eif.mode = mode;
    assign eif.loc = loc;
    assign eif.disp = st.disp;
    assign eif.base_word = base_word;
    assign eif.frame_base_word = frame_base_word;
    assign eif.src_index_word = src_index_word;
    assign eif.dest_index_word = dest_index_word;

    osd_ea_calc u_ea (
        .eif(eif.calc)
    );

    // Next state of the whole decoder
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.state)
            OSD_S_IDLE: begin
                if (take) begin
                    // Opcode byte: its descriptor fixes the operand layout
                    next_st.opcode = byte_data;
                    next_st.fmt = desc_fmt;
                    next_st.imm_size = desc_imm_size; // [RULE_18]
                    next_st.imm_signed = desc_imm_signed;
                    next_st.base_op = desc_base_opcode;
                    next_st.start = start_offset;
                    next_st.len = 4'h1;
                    next_st.spec = 8'h00;
                    next_st.dneed = 2'h0;
                    next_st.dcnt = 2'h0;
                    next_st.cnt = 3'h0;
                    next_st.disp = 16'h0000;
                    next_st.data = 32'h0000_0000;
                    next_st.need = data_bytes(desc_fmt, desc_imm_size);
                    if (has_spec(desc_fmt)) begin
                        next_st.state = OSD_S_SPEC;
                    end else if (data_bytes(desc_fmt, desc_imm_size) != 3'h0) begin
                        next_st.state = OSD_S_DATA;
                    end else begin
                        next_st.state = OSD_S_FIN;
                    end
                end
            end
            OSD_S_SPEC: begin
                if (take) begin
                    next_st.spec = byte_data;
                    next_st.len = st.len + 4'h1;
                    next_st.dneed = disp_bytes(byte_data[OSD_MODE_HI:OSD_MODE_LO],
                        byte_data[OSD_LOC_HI:OSD_LOC_LO]);
                    // Displacement comes first, immediate data after it
                    if (next_st.dneed != 2'h0) begin
                        next_st.state = OSD_S_DISP; // [RULE_03]
                    end else if (st.need != 3'h0) begin
                        next_st.state = OSD_S_DATA;
                    end else begin
                        next_st.state = OSD_S_FIN;
                    end
                end
            end
            OSD_S_DISP: begin
                if (take) begin
                    if (st.dcnt == 2'h0) begin
                        if (mode == OSD_MODE_DISP8) begin
                            next_st.disp = sext8(byte_data); // [RULE_12] [RULE_04]
                        end else begin
                            next_st.disp = {8'h00, byte_data}; // [RULE_09]
                        end
                    end else begin
                        next_st.disp[15:8] = byte_data; // [RULE_13]
                    end
                    next_st.dcnt = st.dcnt + 2'h1;
                    next_st.len = st.len + 4'h1;
                    if (st.dcnt + 2'h1 == st.dneed) begin
                        next_st.state = (st.need != 3'h0) ? OSD_S_DATA : OSD_S_FIN; // [RULE_03]
                    end
                end
            end
            OSD_S_DATA: begin
                if (take) begin
                    // Little-endian assembly of every operand word
                    next_st.data[{st.cnt[1:0], 3'h0} +: 8] = byte_data; // [RULE_09]
                    next_st.cnt = st.cnt + 3'h1;
                    next_st.len = st.len + 4'h1;
                    if (st.cnt + 3'h1 == st.need) begin
                        next_st.state = OSD_S_FIN;
                    end
                end
            end
            OSD_S_FIN: begin
                // All bytes in: publish results, held until the next decode, done high for one cycle
                next_st.done = 1'b1;
                next_st.state = OSD_S_IDLE;
                next_st.instr_len = st.len; // [RULE_19]
                next_st.next_ip = nip; // [RULE_19]
                next_st.ext_digit = st.spec[OSD_REG_HI:OSD_REG_LO]; // [RULE_01]
                if (st.fmt == OSD_F_REG_OP) begin
                    next_st.reg_sel = rdiff[2:0]; // [RULE_10]
                end else begin
                    next_st.reg_sel = st.spec[OSD_REG_HI:OSD_REG_LO]; // [RULE_02]
                end
                next_st.rm_is_reg = has_spec(st.fmt) && (mode == OSD_MODE_REG); // [RULE_14]
                next_st.mem_op = has_spec(st.fmt) && (mode != OSD_MODE_REG);
                next_st.rm_reg = loc; // [RULE_14]
                next_st.ea = next_st.mem_op ? eif.ea : 16'h0000; // [RULE_04]
                // Signedness of a lone immediate byte is the opcode's call
                if (st.imm_size == OSD_IMM_BYTE) begin
                    if (st.imm_signed) begin
                        next_st.imm = sext8(st.data[7:0]); // [RULE_08]
                    end else begin
                        next_st.imm = {8'h00, st.data[7:0]}; // [RULE_08]
                    end
                end else if (st.imm_size == OSD_IMM_WORD) begin
                    next_st.imm = st.data[15:0]; // [RULE_09]
                end else begin
                    next_st.imm = 16'h0000;
                end
                // Branch targets wrap naturally in 16 bits
                case (st.fmt)
                    OSD_F_SHORT_REL: begin
                        next_st.target_ip = nip + sext8(st.data[7:0]); // [RULE_05]
                    end
                    OSD_F_NEAR_REL: begin
                        next_st.target_ip = nip + st.data[15:0]; // [RULE_06]
                    end
                    OSD_F_FAR_PTR: begin
                        next_st.target_ip = st.data[15:0]; // [RULE_07]
                        next_st.target_cs = st.data[31:16]; // [RULE_07]
                    end
                    default: begin
                        next_st.target_ip = nip;
                    end
                endcase
            end
            default: begin
                next_st.state = OSD_S_IDLE;
            end
        endcase
        // Ready is registered, so the cycle spent in OSD_S_FIN, before done rises, refuses new bytes
        next_st.ready = (next_st.state != OSD_S_FIN);
    end

    // State register; reset clears the whole state, published results and ready included
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= osd_state_s'(OSD_RESET_VALUE);
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign byte_ready = st.ready;
    assign dec_done = st.done;
    assign reg_sel = st.reg_sel;
    assign ext_digit = st.ext_digit;
    assign rm_is_reg = st.rm_is_reg;
    assign rm_reg = st.rm_reg;
    assign mem_op = st.mem_op;
    assign effective_address = st.ea;
    assign imm_value = st.imm;
    assign target_ip = st.target_ip;
    assign target_cs = st.target_cs;
    assign instr_len = st.instr_len;
    assign next_ip = st.next_ip;

    // Checks on published results and on fetch order; st fields still hold the operands
    ext_digit_a: assert property (@(posedge clk) disable iff (reset) // [RULE_01]
        st.done && st.fmt == OSD_F_SPEC_EXT |-> ext_digit == st.spec[5:3])
        else $error("sub-opcode digit wrong");
    reg_field_a: assert property (@(posedge clk) disable iff (reset) // [RULE_02]
        st.done && st.fmt == OSD_F_SPEC_REG |-> reg_sel == st.spec[5:3])
        else $error("register operand field wrong");
    disp_first_a: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
        st.state == OSD_S_DATA |-> st.dcnt == st.dneed)
        else $error("data fetched before displacement");
    short_target_a: assert property (@(posedge clk) disable iff (reset) // [RULE_05]
        st.done && st.fmt == OSD_F_SHORT_REL
        |-> target_ip == next_ip + {{8{st.data[7]}}, st.data[7:0]})
        else $error("short branch target wrong");
    near_target_a: assert property (@(posedge clk) disable iff (reset) // [RULE_06]
        st.done && st.fmt == OSD_F_NEAR_REL |-> target_ip == next_ip + st.data[15:0])
        else $error("near branch target wrong");
    far_pointer_a: assert property (@(posedge clk) disable iff (reset) // [RULE_07]
        st.done && st.fmt == OSD_F_FAR_PTR
        |-> {target_cs, target_ip} == st.data && instr_len == 4'h5)
        else $error("far pointer split wrong");
    imm_sign_a: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
        st.done && st.imm_size == OSD_IMM_BYTE
        |-> imm_value[15:8] == (st.imm_signed && st.data[7] ? 8'hFF : 8'h00))
        else $error("immediate byte extension wrong");
    byte_disp_a: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
        take && st.state == OSD_S_DISP && mode == OSD_MODE_DISP8
        |=> st.state != OSD_S_DISP && st.disp == {{8{$past(byte_data[7])}}, $past(byte_data)})
        else $error("byte displacement count wrong");
    direct_addr_a: assert property (@(posedge clk) disable iff (reset) // [RULE_17]
        st.done && st.mem_op && st.spec[7:6] == OSD_MODE_NODISP && st.spec[2:0] == 3'h6
        |-> effective_address == st.disp && st.dneed == 2'h2)
        else $error("direct address wrong");
    length_a: assert property (@(posedge clk) disable iff (reset) // [RULE_19]
        st.done |-> next_ip == st.start + {12'h0, instr_len} && instr_len == st.len)
        else $error("instruction length wrong");

endmodule
`default_nettype wire

/* File: hdl/osd_pkg.sv */
// Shared constants and types for the operand specifier decoder
package osd_pkg;

    // Operand specifier byte field positions
    localparam int OSD_MODE_HI = 7;
    localparam int OSD_MODE_LO = 6;
    localparam int OSD_REG_HI = 5;
    localparam int OSD_REG_LO = 3;
    localparam int OSD_LOC_HI = 2;
    localparam int OSD_LOC_LO = 0;

    // Addressing-form field codes
    localparam logic [1:0] OSD_MODE_NODISP = 2'h0;
    localparam logic [1:0] OSD_MODE_DISP8 = 2'h1;
    localparam logic [1:0] OSD_MODE_DISP16 = 2'h2;
    localparam logic [1:0] OSD_MODE_REG = 2'h3;

    // Locator code that means a direct address when no displacement form
    localparam logic [2:0] OSD_LOC_DIRECT = 3'h6;

    // Operand byte counts
    localparam logic [2:0] OSD_SHORT_BYTES = 3'h1;
    localparam logic [2:0] OSD_NEAR_BYTES = 3'h2;
    localparam logic [2:0] OSD_FAR_BYTES = 3'h4;

    // Immediate size codes from the opcode descriptor
    localparam logic [1:0] OSD_IMM_NONE = 2'h0;
    localparam logic [1:0] OSD_IMM_BYTE = 2'h1;
    localparam logic [1:0] OSD_IMM_WORD = 2'h2;

    // Reset value of the whole decode state
    localparam int OSD_RESET_VALUE = 0;

    // Operand format chosen by the opcode table outside this block
    typedef enum logic [2:0] {
        OSD_F_NONE,
        OSD_F_SPEC_REG,
        OSD_F_SPEC_EXT,
        OSD_F_REG_OP,
        OSD_F_SHORT_REL,
        OSD_F_NEAR_REL,
        OSD_F_FAR_PTR
    } osd_fmt_e;

    typedef enum logic [2:0] {
        OSD_S_IDLE,
        OSD_S_SPEC,
        OSD_S_DISP,
        OSD_S_DATA,
        OSD_S_FIN
    } osd_state_e;

endpackage

/* File: hdl/osd_ea_if.sv */
// Interface between the decoder core and its address calculator
`timescale 1ns/10ps
`default_nettype none
interface osd_ea_if;
    logic [1:0] mode;
    logic [2:0] loc;
    logic [15:0] disp;
    logic [15:0] base_word;
    logic [15:0] frame_base_word;
    logic [15:0] src_index_word;
    logic [15:0] dest_index_word;
    logic [15:0] ea;

    modport calc (
        input mode, loc, disp, base_word, frame_base_word,
        input src_index_word, dest_index_word,
        output ea
    );
    modport user (
        output mode, loc, disp, base_word, frame_base_word,
        output src_index_word, dest_index_word,
        input ea
    );
endinterface
`default_nettype wire

/* File: hdl/osd_ea_calc.sv */
// Effective address calculator for memory operand forms
`timescale 1ns/10ps
`default_nettype none
module osd_ea_calc (
    osd_ea_if.calc eif // Address request and result
);
    import osd_pkg::*;

    // Base and/or index plus signed displacement, or a direct address, modulo 64K
    always_comb begin
        case (eif.loc)
            3'h0: eif.ea = eif.base_word + eif.src_index_word + eif.disp; // [RULE_15]
            3'h1: eif.ea = eif.base_word + eif.dest_index_word + eif.disp; // [RULE_15]
            3'h2: eif.ea = eif.frame_base_word + eif.src_index_word + eif.disp; // [RULE_15]
            3'h3: eif.ea = eif.frame_base_word + eif.dest_index_word + eif.disp; // [RULE_15]
            3'h4: eif.ea = eif.src_index_word + eif.disp; // [RULE_16]
            3'h5: eif.ea = eif.dest_index_word + eif.disp; // [RULE_16]
            3'h6: begin
                // Direct address takes no register at all
                if (eif.mode == OSD_MODE_NODISP) begin
                    eif.ea = eif.disp; // [RULE_17]
                end else begin
                    eif.ea = eif.frame_base_word + eif.disp; // [RULE_16]
                end
            end
            default: eif.ea = eif.base_word + eif.disp; // [RULE_16]
        endcase
    end

endmodule
`default_nettype wire

/* File: verification/osd_fetch_model.sv */
// Fetch model offering code bytes with opcode descriptors
`timescale 1ns/10ps
`default_nettype none
module osd_fetch_model (
    input wire logic clk, // Core clock
    input wire logic reset, // Synchronous reset
    input wire logic stall, // Hold back a new offer this cycle
    input wire logic byte_ready, // Decoder accepts a byte
    output logic byte_valid, // Byte offered
    output logic [7:0] byte_data, // Code byte
    output logic [15:0] start_offset, // Offset of opcode byte
    output osd_pkg::osd_fmt_e desc_fmt, // Operand format
    output logic [1:0] desc_imm_size, // Immediate size
    output logic desc_imm_signed, // Immediate signedness
    output logic [7:0] desc_base_opcode // Base opcode
);
    import osd_pkg::*;
    typedef struct packed {
        logic [7:0] b;
        osd_fmt_e fmt;
        logic [1:0] isz;
        logic isg;
        logic [7:0] base;
        logic [15:0] start;
    } osd_fetch_s;
    osd_fetch_s q[$];

    task automatic push(input osd_fetch_s e);
        q.push_back(e);
    endtask

    initial begin
        {byte_valid, byte_data, start_offset, desc_imm_size} = '0;
        {desc_imm_signed, desc_base_opcode} = '0;
        desc_fmt = OSD_F_NONE;
    end

    // Offer held until taken; toggled idle data exposes stale use
    always @(posedge clk) begin
        if (byte_valid && byte_ready && !reset) q.delete(0);
        if (!reset && q.size() != 0 && (!stall || (byte_valid && !byte_ready))) begin
            byte_valid <= 1'b1;
            byte_data <= q[0].b;
            desc_fmt <= q[0].fmt;
            desc_imm_size <= q[0].isz;
            desc_imm_signed <= q[0].isg;
            desc_base_opcode <= q[0].base;
            start_offset <= q[0].start;
        end else begin
            byte_valid <= 1'b0;
            byte_data <= ~byte_data;
        end
    end
endmodule
`default_nettype wire

/* File: verification/osd_decoder_bench.sv */
// Self-checking bench for the operand specifier decoder
`timescale 1ns/10ps
`default_nettype none
module osd_decoder_bench;
    import osd_pkg::*;
    typedef struct packed {
        logic [2:0] rsel, rmr;
        logic spec, regop, is_reg, mem;
        logic [15:0] ea, imm, tip, tcs, nip;
        logic [3:0] len;
    } osd_exp_s;
    logic clk = 1'b0, reset = 1'b1, stall = 1'b0, stall_en = 1'b0;
    logic byte_valid, byte_ready, desc_imm_signed, dec_done, rm_is_reg, mem_op;
    logic [7:0] byte_data, desc_base_opcode;
    logic [1:0] desc_imm_size;
    osd_fmt_e desc_fmt;
    logic [15:0] start_offset, effective_address, imm_value, target_ip, target_cs, next_ip;
    logic [15:0] base_word, frame_base_word, src_index_word, dest_index_word;
    logic [2:0] reg_sel, ext_digit, rm_reg;
    logic [3:0] instr_len;
    logic [15:0] last_cs = 16'h0000;
    int seed = 32'hCE9B;
    int errors = 0, samples_checked = 0;
    osd_exp_s exp_q[$], m;

    always #2.5 clk = ~clk;

    osd_fetch_model i_osd_fetch_model (.clk(clk), .reset(reset), .stall(stall),
        .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data),
        .start_offset(start_offset), .desc_fmt(desc_fmt), .desc_imm_size(desc_imm_size),
        .desc_imm_signed(desc_imm_signed), .desc_base_opcode(desc_base_opcode));

    osd_decoder i_osd_decoder (.clk(clk), .reset(reset), .byte_valid(byte_valid),
        .byte_data(byte_data), .byte_ready(byte_ready), .start_offset(start_offset),
        .desc_fmt(desc_fmt), .desc_imm_size(desc_imm_size),
        .desc_imm_signed(desc_imm_signed), .desc_base_opcode(desc_base_opcode),
        .base_word(base_word), .frame_base_word(frame_base_word),
        .src_index_word(src_index_word), .dest_index_word(dest_index_word),
        .dec_done(dec_done), .reg_sel(reg_sel), .ext_digit(ext_digit),
        .rm_is_reg(rm_is_reg), .rm_reg(rm_reg), .mem_op(mem_op),
        .effective_address(effective_address), .imm_value(imm_value),
        .target_ip(target_ip), .target_cs(target_cs), .instr_len(instr_len),
        .next_ip(next_ip));

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One instruction's bytes and expected decode
    task automatic issue(input osd_fmt_e fmt, input logic [7:0] op, spec, base,
        input logic [1:0] isz, input logic isg, input logic [15:0] disp, imm, start,
        input logic [31:0] far);
        osd_exp_s e = '0;
        logic [7:0] b[$];
        logic [15:0] dv = 16'h0000;
        b.push_back(op);
        e.spec = fmt inside {OSD_F_SPEC_REG, OSD_F_SPEC_EXT};
        e.regop = fmt == OSD_F_REG_OP;
        e.rsel = e.regop ? 3'(op - base) : spec[5:3];
        if (e.spec) begin
            b.push_back(spec);
            if (spec[7:6] == OSD_MODE_DISP8) begin
                b.push_back(disp[7:0]);
                dv = {{8{disp[7]}}, disp[7:0]};
            end else if (spec[7:6] == OSD_MODE_DISP16 || (spec & 8'hC7) == 8'h06) begin
                b.push_back(disp[7:0]);
                b.push_back(disp[15:8]);
                dv = disp;
            end
            e.mem = spec[7:6] != OSD_MODE_REG;
            e.is_reg = !e.mem;
            e.rmr = spec[2:0];
            case (spec[2:0])
                3'h0: e.ea = base_word + src_index_word;
                3'h1: e.ea = base_word + dest_index_word;
                3'h2: e.ea = frame_base_word + src_index_word;
                3'h3: e.ea = frame_base_word + dest_index_word;
                3'h4: e.ea = src_index_word;
                3'h5: e.ea = dest_index_word;
                3'h6: e.ea = (spec[7:6] == OSD_MODE_NODISP) ? 16'h0000 : frame_base_word;
                default: e.ea = base_word;
            endcase
            e.ea = e.mem ? e.ea + dv : 16'h0000;
        end
        if (fmt == OSD_F_SHORT_REL) b.push_back(disp[7:0]);
        if (fmt == OSD_F_NEAR_REL) b = {b, disp[7:0], disp[15:8]};
        if (fmt == OSD_F_FAR_PTR) b = {b, far[7:0], far[15:8], far[23:16], far[31:24]};
        if (isz == OSD_IMM_BYTE) begin
            b.push_back(imm[7:0]);
            e.imm = isg ? {{8{imm[7]}}, imm[7:0]} : {8'h00, imm[7:0]};
        end else if (isz == OSD_IMM_WORD) begin
            b = {b, imm[7:0], imm[15:8]};
            e.imm = imm;
        end
        e.len = 4'(b.size());
        e.nip = start + {12'h000, e.len};
        case (fmt)
            OSD_F_SHORT_REL: e.tip = e.nip + {{8{disp[7]}}, disp[7:0]};
            OSD_F_NEAR_REL: e.tip = e.nip + disp;
            OSD_F_FAR_PTR: e.tip = far[15:0];
            default: e.tip = e.nip;
        endcase
        if (fmt == OSD_F_FAR_PTR) last_cs = far[31:16];
        e.tcs = last_cs;
        exp_q.push_back(e);
        // Noise on descriptor lines after the opcode
        foreach (b[k]) begin
            if (k == 0) i_osd_fetch_model.push({b[k], fmt, isz, isg, base, start});
            else i_osd_fetch_model.push({b[k], 30'($random(seed))});
        end
    endtask

    // Random fetch stalls
    always @(posedge clk) stall <= stall_en && ($random(seed) % 4 == 0);

    // Compare on the falling edge, once settled
    always @(negedge clk) begin
        if (!reset && dec_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("dec_done", 16'h0000, 16'h0001);
            end else begin
                m = exp_q.pop_front();
                if (m.spec || m.regop) cmp("reg_sel", m.rsel, reg_sel);
                if (m.spec) cmp("ext_digit", m.rsel, ext_digit);
                if (m.spec) cmp("rm_is_reg", m.is_reg, rm_is_reg);
                if (m.spec) cmp("rm_reg", m.rmr, rm_reg);
                cmp("mem_op", m.mem, mem_op);
                cmp("effective_address", m.ea, effective_address);
                cmp("imm_value", m.imm, imm_value);
                cmp("target_ip", m.tip, target_ip);
                cmp("target_cs", m.tcs, target_cs);
                cmp("instr_len", m.len, instr_len);
                cmp("next_ip", m.nip, next_ip);
            end
        end
    end

    // Cuts a hang short
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    // One format per group, all form and locator pairs
    initial begin
        logic [31:0] r, r2, r3;
        logic [15:0] disp, start;
        osd_fmt_e fmt;
        repeat (19) @(posedge clk);
        #1;
        cmp("byte_ready", 16'h0000, byte_ready);
        cmp("dec_done", 16'h0000, dec_done);
        @(posedge clk);
        reset <= 1'b0;
        for (int g = 0; g < 8; g++) begin
            fmt = osd_fmt_e'(g == 7 ? 1 : g);
            r = $random(seed);
            r2 = $random(seed);
            {frame_base_word, base_word} <= r;
            {dest_index_word, src_index_word} <= r2;
            stall_en <= g != 7;
            @(posedge clk);
            for (int i = 0; i < 32; i++) begin
                r = $random(seed);
                r2 = $random(seed);
                r3 = $random(seed);
                disp = r[15:0];
                start = r2[15:0];
                if (i < 2) begin
                    disp[7:0] = (i == 1) ? 8'h7F : 8'h80;
                    start = 16'hFFFE;
                end
                issue(fmt, (fmt == OSD_F_REG_OP) ? r2[23:16] + r2[26:24] : r2[31:24],
                    {i[1:0], r2[29:27], i[4:2]}, r2[23:16],
                    (fmt inside {OSD_F_SHORT_REL, OSD_F_NEAR_REL, OSD_F_FAR_PTR}) ? 2'h0
                    : 2'(i % 3), i[2], disp, r[31:16], start, r3);
            end
            for (int t = 0; t < 3000 && exp_q.size() != 0; t++) @(posedge clk);
            if (exp_q.size() != 0) cmp("pending", 16'h0000, 16'(exp_q.size()));
        end
        repeat (5) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
